//--- conv_far_end.sv
// Purpose: Far-side boards and cabling on the rear and front pins
// Assumes: Far side drives a pin only while the block leaves it undriven
// Notes:   Levels come from the bench; receivers see the resolved wire
`timescale 1ns/100ps
module conv_far_end
(
	// Levels offered by the far side
	input  logic [2:0] far_rear,
	input  logic [7:0] far_line,
	// Block drivers
	input  logic [2:0] rear_out,
	input  logic [2:0] rear_oe,
	input  logic [7:0] line_out,
	input  logic [7:0] line_oe,
	// Resolved levels
	output logic [2:0] rear_in,
	output logic [7:0] line_in
);
	// Block's own level wins where its driver is on, avoiding a fight
	assign rear_in = (rear_oe & rear_out) | (~rear_oe & far_rear);
	assign line_in = (line_oe & line_out) | (~line_oe & far_line);
endmodule // conv_far_end

//--- conv_signal_map.vh
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: 32-bit AXI4-Lite register bus, byte addresses, 100 MHz logic clock
// Notes:   Definitions only; included by the routing and digital port block
`ifndef CONV_SIGNAL_MAP_VH
`define CONV_SIGNAL_MAP_VH

// Register byte offsets (low 12 address bits are decoded)
`define OFS_OUTPUT_ROUTE      12'h340
`define OFS_SOURCE_SELECT     12'h344
`define OFS_FRAME_TIMER_CTRL  12'h348
`define OFS_DIGITAL_INPUT     12'h354
`define OFS_DEBOUNCE          12'h358
`define OFS_DIGITAL_OUTPUT    12'h35c
`define OFS_OUTPUT_ENABLE     12'h360
`define OFS_IRQ_ENABLE        12'h36c
`define OFS_ACK_MODE          12'h380
`define OFS_IRQ_STATUS        12'h384

// Routing and source field positions and codes
`define FLD_CLOCK_A_LSB       0
`define FLD_CLOCK_B_LSB       2
`define FLD_TRIGGER_LSB       4
`define CODE_REAR             2'h2
`define CODE_FRONT            2'h3
`define ROUTE_RESET           6'h00
`define SOURCE_RESET          6'h00

// Front line indices used by the conversion signals
`define LINE_CLOCK_A          0
`define LINE_CLOCK_B          2
`define LINE_TRIGGER          4

// Frame timer control fields
`define BIT_TIMER_ENABLE      31
`define BIT_TIMER_CLOCK_SEL   30
`define BIT_TIMER_EXPIRED     29
`define RELOAD_RESET          28'hfffffff

// Interrupt enable and status bit positions
`define BIT_IRQ_TIMER         29
`define BIT_IRQ_TRIGGER       28

// Debounce timing: unit time in ns and clock period in ns
`define DEBOUNCE_UNIT_NS      50
`define CLK_PERIOD_NS         10
`define DEBOUNCE_UNIT_CYC     20'h00005 // 50 ns over a 10 ns clock
`define DEBOUNCE_RESET        16'h0000

// AXI responses
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

//--- conv_signal_routing_and_dio.v
// Purpose: Conversion signal routing, frame timer and 8-line digital port
// Assumes: Generator signals arrive on aclk; pins are asynchronous to aclk
// Notes:   Rules carried out, one to a line
`timescale 1ns/100ps
`include "conv_signal_map.vh"

module conv_signal_routing_and_dio
(
	// Clock, reset and clock enable
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        clk_en,
	// AXI4-Lite write address and data
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// On-board generator outputs
	input  wire        gen_clock_a,
	input  wire        gen_clock_b,
	input  wire        gen_frame_trigger,
	// Rear connector conversion pins
	input  wire        rear_clock_a_in,
	output wire        rear_clock_a_out,
	output wire        rear_clock_a_oe,
	input  wire        rear_clock_b_in,
	output wire        rear_clock_b_out,
	output wire        rear_clock_b_oe,
	input  wire        rear_trigger_in,
	output wire        rear_trigger_out,
	output wire        rear_trigger_oe,
	// Front digital lines
	input  wire [7:0]  digital_line_in,
	output wire [7:0]  digital_line_out,
	output wire [7:0]  digital_line_oe,
	// Selected conversion signals and status
	output wire        conversion_clock_a,
	output wire        conversion_clock_b,
	output wire        frame_start_trigger,
	output wire        frame_timer_expired,
	output wire        irq_pending
);

	// Source selection shared by the three conversion signals
	function sel_source;
		input [1:0] code;
		input       gen;
		input       rear;
		input       front;
		begin
			if (code == `CODE_REAR)
				sel_source = rear;
			else if (code == `CODE_FRONT)
				sel_source = front;
			else
				sel_source = gen; // Codes 0x and reserved take the generator
		end
	endfunction

	// Byte-lane merge of a write into an old value
	function [31:0] merge_bytes;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer      i;
		begin
			merge_bytes = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge_bytes[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	// Software registers
	reg  [5:0]  route_reg;
	reg  [5:0]  source_reg;
	reg         timer_enable_reg;
	reg         timer_clock_sel_reg;
	reg  [27:0] timer_reload_reg;
	reg  [15:0] debounce_reg;
	reg  [7:0]  drive_value_reg;
	reg  [7:0]  drive_enable_reg;
	reg         irq_en_timer_reg;
	reg         irq_en_trigger_reg;
	reg         ack_on_read_reg;
	reg         irq_timer_reg;
	reg         irq_trigger_reg;

	// Bus state
	reg         aw_held_reg;
	reg  [11:0] aw_addr_reg;
	reg         w_held_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         bvalid_reg;
	reg  [1:0]  bresp_reg;
	reg         rvalid_reg;
	reg  [31:0] rdata_reg;
	reg  [1:0]  rresp_reg;

	// Pin and line state
	reg  [2:0]  rear_s1_reg;
	reg  [2:0]  rear_s2_reg;
	reg  [2:0]  rear_s3_reg;
	reg  [2:0]  rear_lvl_reg;
	reg  [7:0]  line_s1_reg;
	reg  [7:0]  line_s2_reg;
	reg  [7:0]  line_s3_reg;
	reg  [7:0]  line_sync_reg;
	reg  [7:0]  line_level_reg;
	reg  [7:0]  line_out_reg;
	reg  [7:0]  line_oe_reg;
	reg  [2:0]  rear_out_reg;
	reg  [2:0]  rear_oe_reg;

	// Conversion signal and frame timer state
	reg         conv_a_reg;
	reg         conv_b_reg;
	reg         trigger_reg;
	reg         conv_a_prev_reg;
	reg         conv_b_prev_reg;
	reg         trigger_prev_reg;
	reg  [27:0] timer_count_reg;
	reg         timer_running_reg;
	reg         timer_expired_reg;

	wire        write_go;
	wire        read_go;
	wire [31:0] reload_merged;
	wire [31:0] debounce_merged;
	wire [19:0] debounce_cycles;
	wire        trigger_event;
	wire        timer_tick;
	wire        timer_expiry;
	wire        status_wr;
	wire        status_rd;

	// Handshakes: write address and data are ready while their holding slots are free, read address while no read answer waits
	assign s_axi_awready = ~aw_held_reg;
	assign s_axi_wready  = ~w_held_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// The write commits once address and data are both held and no response waits
	assign write_go  = clk_en & aw_held_reg & w_held_reg & ~bvalid_reg;
	assign read_go   = clk_en & s_axi_arvalid & ~rvalid_reg;
	assign reload_merged   = merge_bytes({4'h0, timer_reload_reg}, w_data_reg, w_strb_reg);
	assign debounce_merged = merge_bytes({16'h0000, debounce_reg}, w_data_reg, w_strb_reg);
	assign status_wr = write_go & (aw_addr_reg == `OFS_IRQ_STATUS);
	assign status_rd = read_go & (s_axi_araddr == `OFS_IRQ_STATUS);

	// Address and data capture, in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (s_axi_awvalid && !aw_held_reg)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held_reg)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (write_go)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				case (aw_addr_reg)
					`OFS_OUTPUT_ROUTE, `OFS_SOURCE_SELECT, `OFS_FRAME_TIMER_CTRL,
					`OFS_DIGITAL_INPUT, `OFS_DEBOUNCE, `OFS_DIGITAL_OUTPUT,
					`OFS_OUTPUT_ENABLE, `OFS_IRQ_ENABLE, `OFS_ACK_MODE,
					`OFS_IRQ_STATUS: bresp_reg <= `RESP_OKAY;
					default:         bresp_reg <= `RESP_SLVERR;
				endcase
			end
			else if (bvalid_reg && s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	// Register writes; unwritten byte lanes keep their old contents
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			route_reg           <= `ROUTE_RESET;
			source_reg          <= `SOURCE_RESET;
			timer_enable_reg    <= 1'b0;
			timer_clock_sel_reg <= 1'b0;
			timer_reload_reg    <= `RELOAD_RESET;
			debounce_reg        <= `DEBOUNCE_RESET;
			drive_value_reg     <= 8'h00;
			drive_enable_reg    <= 8'h00;
			irq_en_timer_reg    <= 1'b0;
			irq_en_trigger_reg  <= 1'b0;
			ack_on_read_reg     <= 1'b0;
		end
		else if (write_go)
		begin
			case (aw_addr_reg)
				`OFS_OUTPUT_ROUTE:
					if (w_strb_reg[0])
						route_reg <= w_data_reg[5:0];
				`OFS_SOURCE_SELECT:
					if (w_strb_reg[0])
						source_reg <= w_data_reg[5:0];
				`OFS_FRAME_TIMER_CTRL:
				begin
					timer_reload_reg <= reload_merged[27:0];
					if (w_strb_reg[3])
					begin
						timer_enable_reg    <= w_data_reg[`BIT_TIMER_ENABLE];
						timer_clock_sel_reg <= w_data_reg[`BIT_TIMER_CLOCK_SEL];
					end
				end
				`OFS_DEBOUNCE:
					debounce_reg <= debounce_merged[15:0];
				`OFS_DIGITAL_OUTPUT:
					if (w_strb_reg[0])
						drive_value_reg <= w_data_reg[7:0];
				`OFS_OUTPUT_ENABLE:
					if (w_strb_reg[0])
						drive_enable_reg <= w_data_reg[7:0];
				`OFS_IRQ_ENABLE:
					if (w_strb_reg[3])
					begin
						irq_en_timer_reg   <= w_data_reg[`BIT_IRQ_TIMER];
						irq_en_trigger_reg <= w_data_reg[`BIT_IRQ_TRIGGER];
					end
				`OFS_ACK_MODE:
					if (w_strb_reg[0])
						ack_on_read_reg <= w_data_reg[0];
				default:
					ack_on_read_reg <= ack_on_read_reg;
			endcase
		end
	end

	// Read answer one cycle after the address is taken; reserved bits read zero
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= `RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (read_go)
			begin
				rvalid_reg <= 1'b1;
				rresp_reg  <= `RESP_OKAY;
				case (s_axi_araddr)
					`OFS_OUTPUT_ROUTE:     rdata_reg <= {26'h0000000, route_reg};
					`OFS_SOURCE_SELECT:    rdata_reg <= {26'h0000000, source_reg};
					`OFS_FRAME_TIMER_CTRL: rdata_reg <= {timer_enable_reg,
						timer_clock_sel_reg, timer_expired_reg, 1'b0, timer_reload_reg};
					`OFS_DIGITAL_INPUT:    rdata_reg <= {24'h000000, line_level_reg};
					`OFS_DEBOUNCE:         rdata_reg <= {16'h0000, debounce_reg};
					`OFS_DIGITAL_OUTPUT:   rdata_reg <= {24'h000000, drive_value_reg};
					`OFS_OUTPUT_ENABLE:    rdata_reg <= {24'h000000, drive_enable_reg};
					`OFS_IRQ_ENABLE:       rdata_reg <= {2'h0, irq_en_timer_reg,
						irq_en_trigger_reg, 28'h0000000};
					`OFS_ACK_MODE:         rdata_reg <= {31'h00000000, ack_on_read_reg};
					`OFS_IRQ_STATUS:       rdata_reg <= {2'h0, irq_timer_reg,
						irq_trigger_reg, 28'h0000000};
					default:
					begin
						rdata_reg <= 32'h00000000;
						rresp_reg <= `RESP_SLVERR;
					end
				endcase
			end
			else if (rvalid_reg && s_axi_rready)
				rvalid_reg <= 1'b0;
		end
	end

	// Rear inputs: three stages, the level moves only when stages two and three agree
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rear_s1_reg  <= 3'h0;
			rear_s2_reg  <= 3'h0;
			rear_s3_reg  <= 3'h0;
			rear_lvl_reg <= 3'h0;
		end
		else if (clk_en)
		begin
			rear_s1_reg  <= {rear_trigger_in, rear_clock_b_in, rear_clock_a_in};
			rear_s2_reg  <= rear_s1_reg;
			rear_s3_reg  <= rear_s2_reg;
			rear_lvl_reg <= (rear_s2_reg & rear_s3_reg) |
				(rear_lvl_reg & (rear_s2_reg ^ rear_s3_reg));
		end
	end

	// Stable time needed before a line level changes, in logic clocks
	assign debounce_cycles = ({4'h0, debounce_reg} + 20'h00001) *
		`DEBOUNCE_UNIT_CYC;

	// Per-line synchroniser and debounce filter
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_line
			reg [19:0] stable_cnt_reg;

			// Count while the synchronised level differs from the filtered one
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					line_s1_reg[gi]    <= 1'b0;
					line_s2_reg[gi]    <= 1'b0;
					line_s3_reg[gi]    <= 1'b0;
					line_sync_reg[gi]  <= 1'b0;
					line_level_reg[gi] <= 1'b0;
					stable_cnt_reg     <= 20'h00000;
				end
				else if (clk_en)
				begin
					line_s1_reg[gi] <= digital_line_in[gi];
					line_s2_reg[gi] <= line_s1_reg[gi];
					line_s3_reg[gi] <= line_s2_reg[gi];
					if (line_s2_reg[gi] == line_s3_reg[gi])
						line_sync_reg[gi] <= line_s3_reg[gi];
					// A glitch back to the filtered level restarts the wait
					if (line_sync_reg[gi] == line_level_reg[gi])
						stable_cnt_reg <= 20'h00000;
					else if (stable_cnt_reg + 20'h00001 >= debounce_cycles)
					begin
						line_level_reg[gi] <= line_sync_reg[gi];
						stable_cnt_reg     <= 20'h00000;
					end
					else
						stable_cnt_reg <= stable_cnt_reg + 20'h00001;
				end
			end
		end
	endgenerate

	// Selected conversion signals; front lines come through the filter
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			conv_a_reg       <= 1'b0;
			conv_b_reg       <= 1'b0;
			trigger_reg      <= 1'b0;
			conv_a_prev_reg  <= 1'b0;
			conv_b_prev_reg  <= 1'b0;
			trigger_prev_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			conv_a_reg <= sel_source(source_reg[`FLD_CLOCK_A_LSB +: 2], gen_clock_a,
				rear_lvl_reg[0], line_level_reg[`LINE_CLOCK_A]);
			conv_b_reg <= sel_source(source_reg[`FLD_CLOCK_B_LSB +: 2], gen_clock_b,
				rear_lvl_reg[1], line_level_reg[`LINE_CLOCK_B]);
			trigger_reg <= sel_source(source_reg[`FLD_TRIGGER_LSB +: 2], gen_frame_trigger,
				rear_lvl_reg[2], line_level_reg[`LINE_TRIGGER]);
			conv_a_prev_reg  <= conv_a_reg;
			conv_b_prev_reg  <= conv_b_reg;
			trigger_prev_reg <= trigger_reg;
		end
	end

	assign conversion_clock_a  = conv_a_reg;
	assign conversion_clock_b  = conv_b_reg;
	assign frame_start_trigger = trigger_reg;

	// Events are rising edges of the selected signals
	assign trigger_event = trigger_reg & ~trigger_prev_reg;
	assign timer_tick    = timer_clock_sel_reg ? (conv_b_reg & ~conv_b_prev_reg) :
		(conv_a_reg & ~conv_a_prev_reg);
	assign timer_expiry  = timer_running_reg & ~trigger_event & timer_tick &
		(timer_count_reg == timer_reload_reg);

	// Frame timer: a trigger restarts it, the reload+1-th clock edge expires it
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_count_reg   <= 28'h0000000;
			timer_running_reg <= 1'b0;
			timer_expired_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!timer_enable_reg)
				timer_running_reg <= 1'b0;
			else if (trigger_event)
			begin
				timer_count_reg   <= 28'h0000000;
				timer_running_reg <= 1'b1;
			end
			else if (timer_expiry)
				timer_running_reg <= 1'b0;
			else if (timer_running_reg && timer_tick)
				timer_count_reg <= timer_count_reg + 28'h0000001;
			// The trigger clears the flag whether or not the timer runs
			if (trigger_event)
				timer_expired_reg <= 1'b0;
			else if (timer_expiry)
				timer_expired_reg <= 1'b1;
		end
	end

	assign frame_timer_expired = timer_expired_reg;

	// Interrupt status: enable sampled before the event; set wins over acknowledge
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_timer_reg   <= 1'b0;
			irq_trigger_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (timer_expiry && irq_en_timer_reg)
				irq_timer_reg <= 1'b1;
			else if ((status_wr && !ack_on_read_reg && w_strb_reg[3] &&
				w_data_reg[`BIT_IRQ_TIMER]) || (status_rd && ack_on_read_reg))
				irq_timer_reg <= 1'b0;
			if (trigger_event && irq_en_trigger_reg)
				irq_trigger_reg <= 1'b1;
			else if ((status_wr && !ack_on_read_reg && w_strb_reg[3] &&
				w_data_reg[`BIT_IRQ_TRIGGER]) || (status_rd && ack_on_read_reg))
				irq_trigger_reg <= 1'b0;
		end
	end

	assign irq_pending = irq_timer_reg | irq_trigger_reg;

	// Pin drivers: enabled digital output wins over any generator route
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			line_out_reg <= 8'h00;
			line_oe_reg  <= 8'h00;
			rear_out_reg <= 3'h0;
			rear_oe_reg  <= 3'h0;
		end
		else if (clk_en)
		begin
			line_out_reg <= drive_value_reg;
			line_oe_reg  <= drive_enable_reg;
			if (!drive_enable_reg[`LINE_CLOCK_A] &&
				route_reg[`FLD_CLOCK_A_LSB +: 2] == `CODE_FRONT)
			begin
				line_out_reg[`LINE_CLOCK_A] <= gen_clock_a;
				line_oe_reg[`LINE_CLOCK_A]  <= 1'b1;
			end
			if (!drive_enable_reg[`LINE_CLOCK_B] &&
				route_reg[`FLD_CLOCK_B_LSB +: 2] == `CODE_FRONT)
			begin
				line_out_reg[`LINE_CLOCK_B] <= gen_clock_b;
				line_oe_reg[`LINE_CLOCK_B]  <= 1'b1;
			end
			if (!drive_enable_reg[`LINE_TRIGGER] &&
				route_reg[`FLD_TRIGGER_LSB +: 2] == `CODE_FRONT)
			begin
				line_out_reg[`LINE_TRIGGER] <= gen_frame_trigger;
				line_oe_reg[`LINE_TRIGGER]  <= 1'b1;
			end
			rear_out_reg <= {gen_frame_trigger, gen_clock_b, gen_clock_a};
			rear_oe_reg  <= {route_reg[`FLD_TRIGGER_LSB +: 2] == `CODE_REAR,
				route_reg[`FLD_CLOCK_B_LSB +: 2] == `CODE_REAR,
				route_reg[`FLD_CLOCK_A_LSB +: 2] == `CODE_REAR};
		end
	end

	assign digital_line_out = line_out_reg;
	assign digital_line_oe  = line_oe_reg;
	assign rear_clock_a_out = rear_out_reg[0];
	assign rear_clock_a_oe  = rear_oe_reg[0];
	assign rear_clock_b_out = rear_out_reg[1];
	assign rear_clock_b_oe  = rear_oe_reg[1];
	assign rear_trigger_out = rear_out_reg[2];
	assign rear_trigger_oe  = rear_oe_reg[2];

endmodule // conv_signal_routing_and_dio

//--- conv_signal_routing_and_dio_props.sv
// Purpose: Pin and bus checks for the routing and digital port block
// Assumes: clk_en held high, so every edge is a working edge
// Notes:   Bound to the top module from the bench
`timescale 1ns/100ps
module conv_signal_routing_and_dio_props
(
	// Clock and reset
	input logic        aclk,
	input logic        aresetn,
	// Bus answers
	input logic        s_axi_arready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	// Generators and rear pins
	input logic        gen_clock_a,
	input logic        gen_clock_b,
	input logic        gen_frame_trigger,
	input logic        rear_clock_a_out,
	input logic        rear_clock_a_oe,
	input logic        rear_clock_b_out,
	input logic        rear_clock_b_oe,
	input logic        rear_trigger_out,
	input logic        rear_trigger_oe,
	// Selected signals and status
	input logic        frame_start_trigger,
	input logic        frame_timer_expired,
	input logic        irq_pending
);
	logic [2:0] ack_seen_reg;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Recent response activity; an acknowledge needs a bus access
	always @(posedge aclk)
		ack_seen_reg <= {ack_seen_reg[1:0], s_axi_bvalid | s_axi_rvalid};

	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	rear_a_route_a: assert property (rear_clock_a_oe |->
		rear_clock_a_out == $past(gen_clock_a)) else $error("rear clock a not the generator");
	rear_b_route_a: assert property (rear_clock_b_oe |->
		rear_clock_b_out == $past(gen_clock_b)) else $error("rear clock b not the generator");
	rear_trig_route_a: assert property (rear_trigger_oe |->
		rear_trigger_out == $past(gen_frame_trigger)) else $error("rear trigger wrong");
	expired_clear_a: assert property ($fell(frame_timer_expired) |->
		$past(frame_start_trigger) || $past(frame_start_trigger, 2) ||
		$past(frame_start_trigger, 3)) else $error("flag lost");
	irq_hold_a: assert property ($fell(irq_pending) |->
		(|ack_seen_reg) || s_axi_bvalid || s_axi_rvalid)
		else $error("pending cleared without acknowledge");

	// Main scenarios reached
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property ($rose(frame_timer_expired));
	cover property ($rose(irq_pending));
endmodule // conv_signal_routing_and_dio_props

//--- conv_signal_routing_and_dio_test.sv
// Purpose: Self-checking bench for the routing and digital port block
// Assumes: clk_en tied high; full byte strobes but for one write
// Notes:   Fixed-seed xorshift data with hand-picked corner cases
`timescale 1ns/100ps
module conv_signal_routing_and_dio_test;
	logic        aclk, aresetn, clk_en, gen_clock_a, gen_clock_b, gen_frame_trigger;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        rear_clock_a_in, rear_clock_a_out, rear_clock_a_oe;
	logic        rear_clock_b_in, rear_clock_b_out, rear_clock_b_oe;
	logic        rear_trigger_in, rear_trigger_out, rear_trigger_oe;
	logic [7:0]  digital_line_in, digital_line_out, digital_line_oe, far_line, m, e8;
	logic [2:0]  far_rear;
	logic        conversion_clock_a, conversion_clock_b, frame_start_trigger;
	logic        frame_timer_expired, irq_pending;
	int          fails, checks;
	localparam logic [11:0] ofs [7] = '{12'h340, 12'h344, 12'h348, 12'h358, 12'h35c, 12'h360, 12'h36c};
	localparam logic [31:0] msk [7] = '{32'h3f, 32'h3f, 32'hcfffffff, 32'hffff, 32'hff, 32'hff,
		32'h30000000};

	conv_signal_routing_and_dio conv_signal_routing_and_dio_i (.*);
	conv_far_end conv_far_end_i
	(
		.far_rear (far_rear),
		.far_line (far_line),
		.rear_out ({rear_trigger_out, rear_clock_b_out, rear_clock_a_out}),
		.rear_oe  ({rear_trigger_oe, rear_clock_b_oe, rear_clock_a_oe}),
		.line_out (digital_line_out),
		.line_oe  (digital_line_oe),
		.rear_in  ({rear_trigger_in, rear_clock_b_in, rear_clock_a_in}),
		.line_in  (digital_line_in)
	);

	// 100 MHz logic clock
	initial
	begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Level a source code selects: rear input, front line, else generator
	function logic pick(input logic [1:0] c, input logic g, input logic r, input logic l);
		return (c == 2'h2) ? r : (c == 2'h3) ? l : g;
	endfunction
	task wc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Ready is sampled a half cycle ahead; it is settled and held to the edge
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ga, gw, t;
		logic [1:0] r;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do
		begin
			@(negedge aclk);
			ga = s_axi_awvalid & s_axi_awready;
			gw = s_axi_wvalid & s_axi_wready;
			t = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ga) s_axi_awvalid <= 0;
			if (gw) s_axi_wvalid <= 0;
		end while (!t);
		s_axi_bready <= 1;
		wc(1);
		s_axi_bready <= 0;
		chk("bresp", er, r);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic g, t;
		logic [31:0] d;
		logic [1:0] r;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do
		begin
			@(negedge aclk);
			g = s_axi_arvalid & s_axi_arready;
			t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (g) s_axi_arvalid <= 0;
		end while (!t);
		s_axi_rready <= 1;
		wc(1);
		s_axi_rready <= 0;
		chk("rresp", er, r);
		chk("rdata", e, d);
	endtask
	task trig();
		gen_frame_trigger <= 1;
		wc(4);
		gen_frame_trigger <= 0;
		wc(4);
	endtask
	task tick(input logic b, input int n);
		repeat (n)
		begin
			gen_clock_a <= !b;
			gen_clock_b <= b;
			wc(4);
			gen_clock_a <= 0;
			gen_clock_b <= 0;
			wc(4);
		end
	endtask
	task results();
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		seed = 32'h0000b0aa;
		fails = 0;
		checks = 0;
		clk_en = 1;
		aresetn = 0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		{gen_clock_a, gen_clock_b, gen_frame_trigger, far_rear, far_line} = 14'h0;
		wc(5);
		aresetn <= 1;
		wc(1);
		// Reset values, random readback, unmapped places
		for (int i = 0; i < 7; i++) rdc(ofs[i], (i == 2) ? 32'h0fffffff : 32'h0, 2'h0);
		for (int i = 0; i < 7; i++)
		begin
			v = rnd();
			wr(ofs[i], v, 2'h0);
			rdc(ofs[i], v & msk[i], 2'h0);
		end
		rdc(12'h350, 32'h0, 2'h2);
		wr(12'h3f0, v, 2'h2);
		wr(12'h358, 32'h0, 2'h0);
		// Every route code against random output values and enables
		for (int i = 0; i < 4; i++)
		begin
			v = rnd();
			{gen_clock_a, gen_clock_b, gen_frame_trigger} <= {3{v[16]}};
			wr(12'h340, {26'h0, {3{i[1:0]}}}, 2'h0);
			wr(12'h35c, v, 2'h0);
			wr(12'h360, {24'h0, v[15:8]}, 2'h0);
			wc(3);
			m = (i == 3) ? 8'h15 : 8'h00;
			e8 = (v[7:0] & v[15:8]) | (m & ~v[15:8] & {8{v[16]}});
			chk("rear oe", {3{i == 2}},
				{rear_trigger_oe, rear_clock_b_oe, rear_clock_a_oe});
			chk("line oe", v[15:8] | m, digital_line_oe);
			chk("line out", e8, digital_line_out & (v[15:8] | m));
			wc(12);
			rdc(12'h354, {24'h0, e8}, 2'h0);
		end
		// Every source code with random levels on all three sources
		wr(12'h340, 32'h0, 2'h0);
		wr(12'h360, 32'h0, 2'h0);
		for (int i = 0; i < 8; i++)
		begin
			v = rnd();
			{gen_frame_trigger, gen_clock_b, gen_clock_a} <= v[2:0];
			far_rear <= v[5:3];
			far_line <= v[15:8];
			wr(12'h344, {26'h0, {3{i[1:0]}}}, 2'h0);
			wc(20);
			chk("clock a", pick(i[1:0], v[0], v[3], v[8]), conversion_clock_a);
			chk("clock b", pick(i[1:0], v[1], v[4], v[10]), conversion_clock_b);
			chk("trigger", pick(i[1:0], v[2], v[5], v[12]), frame_start_trigger);
			rdc(12'h354, {24'h0, v[15:8]}, 2'h0);
		end
		// A single-lane write keeps the other byte lanes
		s_axi_wstrb <= 4'h1;
		wr(12'h358, 32'h0000abcd, 2'h0);
		s_axi_wstrb <= 4'hf;
		rdc(12'h358, 32'h000000cd, 2'h0);
		// Filter of two units: a 90 ns pulse is lost, a held level passes
		far_line <= 0;
		wr(12'h358, 32'h1, 2'h0);
		wc(20);
		far_line <= 8'h80;
		wc(9);
		far_line <= 0;
		repeat (5) rdc(12'h354, 32'h0, 2'h0);
		far_line <= 8'h80;
		wc(20);
		rdc(12'h354, 32'h80, 2'h0);
		// Timer on clock A, reload 3, restarted by a second trigger
		far_line <= 0;
		{gen_clock_a, gen_clock_b, gen_frame_trigger} <= 3'h0;
		wr(12'h344, 32'h0, 2'h0);
		wr(12'h36c, 32'h30000000, 2'h0);
		wr(12'h384, 32'h30000000, 2'h0);
		wr(12'h348, 32'h80000003, 2'h0);
		trig();
		chk("cleared", 0, frame_timer_expired);
		tick(0, 2);
		trig();
		tick(0, 3);
		chk("restart", 0, frame_timer_expired);
		tick(0, 1);
		chk("expired", 1, frame_timer_expired);
		rdc(12'h384, 32'h30000000, 2'h0);
		wr(12'h36c, 32'h0, 2'h0);
		rdc(12'h384, 32'h30000000, 2'h0);
		wr(12'h384, 32'h30000000, 2'h0);
		rdc(12'h384, 32'h0, 2'h0);
		trig();
		chk("masked", 0, irq_pending);
		chk("flag clear", 0, frame_timer_expired);
		// Timer on clock B ignores clock A
		wr(12'h348, 32'hc0000000, 2'h0);
		wr(12'h36c, 32'h20000000, 2'h0);
		trig();
		tick(0, 2);
		chk("other clock", 0, frame_timer_expired);
		tick(1, 1);
		chk("clock b irq", 1, irq_pending);
		// Acknowledge by reading the status word
		wr(12'h380, 32'h1, 2'h0);
		rdc(12'h384, 32'h20000000, 2'h0);
		rdc(12'h384, 32'h0, 2'h0);
		results();
	end

	// Hang guard, far beyond the several hundred cycles the run needs
	initial
	begin
		wc(30000);
		fails++;
		results();
	end
endmodule // conv_signal_routing_and_dio_test

bind conv_signal_routing_and_dio conv_signal_routing_and_dio_props conv_signal_routing_and_dio_props_i (.*);
